// ==== verilog/pcf_regs.svh ====
/*
  Constants for the peak-cancellation input and filter block: widths,
  tap counts, fifo depth and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
`define PCF_DW        16
`define PCF_CW        16
`define PCF_ANT       4
`define PCF_TAPS      7
`define PCF_HALF      3
`define PCF_STAGES    2
`define PCF_FIFO_DEP  16
`define PCF_CSHIFT    15
`define PCF_THR_RST   16'h4000
`define PCF_CTR_RST   16'h7fff
`endif

// ==== verilog/pcf_pkg.sv ====
/*
  Types shared by the peak-cancellation input and filter block.
  Assumes pcf_regs.svh is on the include path.
*/
`include "pcf_regs.svh"
package pcf_pkg;
  typedef struct packed {
    logic signed [`PCF_DW-1:0] i;
    logic signed [`PCF_DW-1:0] q;
  } pcf_iq_type;

  typedef pcf_iq_type [`PCF_ANT-1:0] pcf_frame_type;

  typedef struct packed {
    logic signed [`PCF_CW-1:0] i;
    logic signed [`PCF_CW-1:0] q;
  } pcf_coef_type;

  typedef pcf_coef_type [`PCF_HALF:0] pcf_half_type;
endpackage

// ==== verilog/pcf_cfr_input.sv ====
/*
  Peak-cancellation input capture, sample fifo and cancellation stages.
  Assumes one clock clk_sys, upstream logic synchronous to it, and a
  downstream consumer that drains the output with out_ready.
*/
`timescale 1ns/1ps
`include "pcf_regs.svh"

// sample fifo: flop storage, count based full and empty
module pcf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clr,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, rp_q;
  logic [AW:0]      cnt_q;
  wire              push = wr_valid && wr_ready;
  wire              pop  = rd_valid && rd_ready;

  assign wr_ready = (cnt_q != DEPTH[AW:0]);
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem_q[rp_q];

  // pointers and count; clr is the synchronous re-initialise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wp_q] <= wr_data;
  end
endmodule

// one cancellation stage for one antenna
module pcf_stage import pcf_pkg::*; #(
  parameter bit COMPLEX = 1'b1
) (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic                     clr,
  input  wire logic                     adv,
  input  wire pcf_iq_type               din,
  input  wire logic     [`PCF_DW-1:0]   thr,
  input  wire pcf_half_type             coef,
  output pcf_iq_type                    dout
);
  localparam int DW = `PCF_DW;
  localparam int AW = DW + `PCF_CW + 4;
  pcf_iq_type                 line_q [`PCF_TAPS];
  pcf_iq_type                 err_q  [`PCF_TAPS];
  pcf_iq_type                 err_d, dout_q;
  pcf_coef_type               tap    [`PCF_TAPS];
  logic signed [AW-1:0]       acc_i, acc_q;
  logic signed [DW:0]         dif_i, dif_q;

  function automatic logic signed [DW-1:0] excess(
    input logic signed [DW-1:0] x, input logic [DW-1:0] t);
    logic signed [DW:0] t1;
    logic signed [DW:0] xe;
    // both sides signed, or a negative sample would compare as huge
    t1 = $signed({1'b0, t});
    xe = $signed({x[DW-1], x});
    if (xe > t1) excess = DW'(xe - t1);
    else if (xe < -t1) excess = DW'(xe + t1);
    else excess = '0;
  endfunction

  function automatic logic signed [DW-1:0] sat(input logic signed [DW:0] v);
    if (v[DW] != v[DW-1]) sat = v[DW] ? {1'b1, {(DW-1){1'b0}}}
                                      : {1'b0, {(DW-1){1'b1}}};
    else sat = v[DW-1:0];
  endfunction

  // full tap set unfolded from the stored half; real build drops q
  always_comb begin
    for (int k = 0; k < `PCF_TAPS; k++) begin
      if (k <= `PCF_HALF) tap[k] = coef[k];
      else begin
        tap[k].i = coef[`PCF_TAPS-1-k].i;
        tap[k].q = -coef[`PCF_TAPS-1-k].q;
      end
      if (k == `PCF_HALF || !COMPLEX) tap[k].q = '0;
    end
  end

  // correction is the tap set convolved with the excess history
  always_comb begin
    acc_i = '0;
    acc_q = '0;
    for (int k = 0; k < `PCF_TAPS; k++) begin
      acc_i = acc_i + AW'(tap[k].i * err_q[k].i)
                    - AW'(tap[k].q * err_q[k].q);
      acc_q = acc_q + AW'(tap[k].i * err_q[k].q)
                    + AW'(tap[k].q * err_q[k].i);
    end
  end

  assign err_d.i = excess(din.i, thr);
  assign err_d.q = excess(din.q, thr);
  // delayed input by half the order minus the correction
  assign dif_i = {line_q[`PCF_HALF].i[DW-1], line_q[`PCF_HALF].i}
               - (DW+1)'(acc_i >>> `PCF_CSHIFT);
  assign dif_q = {line_q[`PCF_HALF].q[DW-1], line_q[`PCF_HALF].q}
               - (DW+1)'(acc_q >>> `PCF_CSHIFT);
  assign dout  = dout_q;

  // state moves only on adv or clr, so a low clock enable freezes it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < `PCF_TAPS; k++) begin
        line_q[k] <= '0;
        err_q[k]  <= '0;
      end
      dout_q <= '0;
    end else if (clr) begin
      for (int k = 0; k < `PCF_TAPS; k++) begin
        line_q[k] <= '0;
        err_q[k]  <= '0;
      end
      dout_q <= '0;
    end else if (adv) begin
      line_q[0] <= din;
      err_q[0]  <= err_d;
      for (int k = 1; k < `PCF_TAPS; k++) begin
        line_q[k] <= line_q[k-1];
        err_q[k]  <= err_q[k-1];
      end
      dout_q.i <= sat(dif_i);
      dout_q.q <= sat(dif_q);
    end
  end

  chk_stage_delay: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    adv && !clr && err_q[0] == '0 && err_q[1] == '0 && err_q[2] == '0 &&
    err_q[3] == '0 && err_q[4] == '0 && err_q[5] == '0 && err_q[6] == '0
    |=> dout_q == $past(line_q[`PCF_HALF]))
    else $error("stage output is not the half-order delayed input");
  chk_centre_quad: assert property (
    @(posedge clk_sys) disable iff (!resetn) tap[`PCF_HALF].q == '0)
    else $error("centre tap quadrature is not zero");
  chk_mirror_taps: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    tap[0].i == tap[6].i && tap[0].q == -tap[6].q &&
    tap[1].i == tap[5].i && tap[1].q == -tap[5].q)
    else $error("mirrored taps are not conjugate");
endmodule

module pcf_cfr_input import pcf_pkg::*; #(
  parameter int NUM_ANT     = 4,
  parameter bit COMPLEX     = 1'b1,
  parameter bit INTERLEAVED = 1'b0
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire logic                   sync_reset_in,
  input  wire logic [`PCF_DW-1:0]     ant0_in_inphase,
  input  wire logic [`PCF_DW-1:0]     ant0_in_quadrature,
  input  wire logic [`PCF_DW-1:0]     ant1_in_inphase,
  input  wire logic [`PCF_DW-1:0]     ant1_in_quadrature,
  input  wire logic [`PCF_DW-1:0]     ant2_in_inphase,
  input  wire logic [`PCF_DW-1:0]     ant2_in_quadrature,
  input  wire logic [`PCF_DW-1:0]     ant3_in_inphase,
  input  wire logic [`PCF_DW-1:0]     ant3_in_quadrature,
  input  wire logic [`PCF_DW-1:0]     ant0_in_interleaved,
  input  wire logic [`PCF_DW-1:0]     ant1_in_interleaved,
  input  wire logic [`PCF_DW-1:0]     ant2_in_interleaved,
  input  wire logic [`PCF_DW-1:0]     ant3_in_interleaved,
  input  wire logic                   in_phase_inphase,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic                   coef_wr_en,
  input  wire logic [0:0]             coef_wr_stage,
  input  wire logic [1:0]             coef_wr_tap,
  input  wire pcf_coef_type           coef_wr_data,
  input  wire logic [`PCF_DW-1:0]     stage_threshold [`PCF_STAGES],
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output pcf_frame_type               out_frame
);
  pcf_half_type                 coef_q  [`PCF_STAGES];
  logic         [`PCF_DW-1:0]   hold_q  [`PCF_ANT];
  logic         [`PCF_DW-1:0]   sp_i    [`PCF_ANT];
  logic         [`PCF_DW-1:0]   sp_q    [`PCF_ANT];
  logic         [`PCF_DW-1:0]   tdm     [`PCF_ANT];
  pcf_frame_type                frame_in, fifo_out;
  pcf_frame_type                chain   [`PCF_STAGES+1];
  logic                         out_valid_q, fifo_rvalid, fifo_wready;

  assign sp_i = '{ant0_in_inphase, ant1_in_inphase,
                  ant2_in_inphase, ant3_in_inphase};
  assign sp_q = '{ant0_in_quadrature, ant1_in_quadrature,
                  ant2_in_quadrature, ant3_in_quadrature};
  assign tdm  = '{ant0_in_interleaved, ant1_in_interleaved,
                  ant2_in_interleaved, ant3_in_interleaved};

  // capture and push decode; an I phase is held, the Q phase pushes
  wire take     = in_valid && in_ready;
  wire take_i   = take && INTERLEAVED && in_phase_inphase;
  wire push     = take && !(INTERLEAVED && in_phase_inphase);
  wire clr      = sync_reset_in && clk_en;
  wire adv      = fifo_rvalid && clk_en && !clr && (!out_valid_q || out_ready);
  assign in_ready  = fifo_wready && clk_en && !clr;
  assign out_valid = out_valid_q;
  assign out_frame = chain[`PCF_STAGES];
  assign chain[0]  = fifo_out;

  // absent antennas read as zero so their ports are inert
  always_comb begin
    for (int a = 0; a < `PCF_ANT; a++) begin
      if (a >= NUM_ANT) frame_in[a] = '0;
      else if (INTERLEAVED) begin
        frame_in[a].i = hold_q[a];
        frame_in[a].q = tdm[a];
      end else begin
        frame_in[a].i = sp_i[a];
        frame_in[a].q = sp_q[a];
      end
    end
  end

  // in-phase holding and run-time coefficient writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_q      <= '{default: '0};
      out_valid_q <= 1'b0;
      for (int s = 0; s < `PCF_STAGES; s++) begin
        coef_q[s] <= '0;
        coef_q[s][`PCF_HALF].i <= `PCF_CTR_RST;
      end
    end else if (clr) begin
      hold_q      <= '{default: '0};
      out_valid_q <= 1'b0;
    end else if (clk_en) begin
      for (int a = 0; a < `PCF_ANT; a++)
        if (take_i) hold_q[a] <= tdm[a];
      if (coef_wr_en) begin
        coef_q[coef_wr_stage][coef_wr_tap] <= coef_wr_data;
      end
      if (adv) out_valid_q <= 1'b1;
      else if (out_ready) out_valid_q <= 1'b0;
    end
  end

  pcf_fifo #(
    .WIDTH ($bits(pcf_frame_type)),
    .DEPTH (`PCF_FIFO_DEP)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clr      (clr),
    .wr_valid (push && clk_en),
    .wr_ready (fifo_wready),
    .wr_data  (frame_in),
    .rd_valid (fifo_rvalid),
    .rd_ready (adv),
    .rd_data  (fifo_out)
  );

  // stages in series, one instance per stage and antenna
  for (genvar s = 0; s < `PCF_STAGES; s++) begin : g_stage
    for (genvar a = 0; a < `PCF_ANT; a++) begin : g_ant
      pcf_stage #(.COMPLEX(COMPLEX)) u_stage (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .clr     (clr),
        .adv     (adv),
        .din     (chain[s][a]),
        .thr     (stage_threshold[s]),
        .coef    (coef_q[s]),
        .dout    (chain[s+1][a])
      );
    end
  end

  chk_ready_full: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    in_ready |-> u_fifo.cnt_q < 5'h10 && clk_en && !clr)
    else $error("ready raised while the fifo is full");
  chk_capture_valid: assert property (
    @(posedge clk_sys) disable iff (!resetn) u_fifo.push |-> in_valid)
    else $error("sample captured without input valid");
  chk_ce_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !clk_en |=> $stable(out_valid_q) && $stable(out_frame))
    else $error("state moved while clock enable low");
  chk_sync_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    clr |-> !in_ready ##1 (!out_valid_q && !fifo_rvalid))
    else $error("sync reset did not clear the core");
  chk_coef_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    coef_wr_en && clk_en && !clr |=>
    coef_q[$past(coef_wr_stage)][$past(coef_wr_tap)] == $past(coef_wr_data))
    else $error("coefficient write was lost");
  chk_tdm_pairing: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    INTERLEAVED && take && in_phase_inphase |-> !u_fifo.push)
    else $error("in-phase half pushed as a whole sample");
endmodule

// ==== bench/pcf_src.sv ====
/*
  Upstream sample source model for the peak-cancellation input block.
  Assumes one clock clk_sys and a combinational in_ready from the block.
*/
`timescale 1ns/1ps
`include "pcf_regs.svh"

// upstream source: offers one frame at a time and holds it until taken
module pcf_src import pcf_pkg::*; (
  input  wire logic          clk_sys,
  input  wire logic          in_ready,
  output logic               in_valid,
  output pcf_frame_type      frame,
  output logic [`PCF_DW-1:0] word,
  output logic               phase
);
  initial begin
    in_valid = 1'b0;
    frame    = '0;
    word     = 16'h5a5a;
    phase    = 1'b0;
  end

  // interleaved lines are unused in split builds; they toggle each cycle
  // so that a design reading them by mistake shows it
  always @(posedge clk_sys) begin
    word  <= ~word;
    phase <= ~phase;
  end

  // ready is read at the falling edge, before the edge that takes the frame
  task automatic send(input pcf_frame_type f, input int lim, output bit ok);
    bit r;
    ok = 1'b0;
    in_valid <= 1'b1;
    frame    <= f;
    for (int n = 0; n < lim && !ok; n++) begin
      @(negedge clk_sys);
      r = in_ready;
      @(posedge clk_sys);
      ok = r;
    end
  endtask

  // released lines carry the inverse, never the last frame
  task automatic idle();
    in_valid <= 1'b0;
    frame    <= ~frame;
  endtask
endmodule

// ==== bench/pcf_bench.sv ====
/*
  Self-checking bench for the peak-cancellation input and filter block.
  Assumes the split format build with four antennas and the source model,
  plus an interleaved real-tap build with two antennas driven here.
*/
`timescale 1ns/1ps
`include "pcf_regs.svh"
`define CHK(got, want) begin n_tests++; if ((got) !== (want)) begin \
  bad_count++; $display("unexpected at %0t: got %0h want %0h", \
  $time, got, want); end end

module peak_cancel_cfr_input_and_filter_bench import pcf_pkg::*;;
  logic                clk_sys = 1'b0;
  logic                resetn = 1'b0;
  logic                clk_en = 1'b1;
  logic                sync_reset_in = 1'b0;
  logic                out_ready = 1'b1;
  logic                coef_wr_en = 1'b0;
  logic [0:0]          coef_wr_stage = 1'b0;
  logic [1:0]          coef_wr_tap = 2'h0;
  pcf_coef_type        coef_wr_data = '0;
  logic [`PCF_DW-1:0]  thr [`PCF_STAGES] = '{default: 16'h7fff};
  logic                in_valid, in_ready, out_valid, phase;
  logic [`PCF_DW-1:0]  word;
  pcf_frame_type       frame, out_frame;
  int                  bad_count = 0;
  int                  n_tests = 0;
  pcf_frame_type       outq [$];
  logic                tdm_valid = 1'b0;
  logic                tdm_phase = 1'b0;
  logic [`PCF_DW-1:0]  tdm_word = 16'h0000;
  logic                tdm_ready, tdm_ov;
  pcf_frame_type       tdm_of;
  pcf_frame_type       tdm_q [$];

  always #25 clk_sys = ~clk_sys;

  pcf_src src (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .frame(frame), .word(word), .phase(phase));

  pcf_cfr_input dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .sync_reset_in(sync_reset_in),
    .ant0_in_inphase(frame[0].i), .ant0_in_quadrature(frame[0].q),
    .ant1_in_inphase(frame[1].i), .ant1_in_quadrature(frame[1].q),
    .ant2_in_inphase(frame[2].i), .ant2_in_quadrature(frame[2].q),
    .ant3_in_inphase(frame[3].i), .ant3_in_quadrature(frame[3].q),
    .ant0_in_interleaved(word), .ant1_in_interleaved(word),
    .ant2_in_interleaved(word), .ant3_in_interleaved(word),
    .in_phase_inphase(phase), .in_valid(in_valid), .in_ready(in_ready),
    .coef_wr_en(coef_wr_en), .coef_wr_stage(coef_wr_stage),
    .coef_wr_tap(coef_wr_tap), .coef_wr_data(coef_wr_data),
    .stage_threshold(thr), .out_valid(out_valid), .out_ready(out_ready),
    .out_frame(out_frame));

  // second build: interleaved words, real taps, two live antennas
  pcf_cfr_input #(.NUM_ANT(2), .COMPLEX(1'b0), .INTERLEAVED(1'b1)) dut_tdm (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .sync_reset_in(sync_reset_in),
    .ant0_in_inphase(frame[0].i), .ant0_in_quadrature(frame[0].q),
    .ant1_in_inphase(frame[1].i), .ant1_in_quadrature(frame[1].q),
    .ant2_in_inphase(frame[2].i), .ant2_in_quadrature(frame[2].q),
    .ant3_in_inphase(frame[3].i), .ant3_in_quadrature(frame[3].q),
    .ant0_in_interleaved(tdm_word), .ant1_in_interleaved(tdm_word),
    .ant2_in_interleaved(tdm_word), .ant3_in_interleaved(tdm_word),
    .in_phase_inphase(tdm_phase), .in_valid(tdm_valid),
    .in_ready(tdm_ready),
    .coef_wr_en(coef_wr_en), .coef_wr_stage(coef_wr_stage),
    .coef_wr_tap(coef_wr_tap), .coef_wr_data(coef_wr_data),
    .stage_threshold(thr), .out_valid(tdm_ov), .out_ready(out_ready),
    .out_frame(tdm_of));

  // collect accepted frames; a frozen core hands nothing over
  always @(posedge clk_sys) begin
    if (resetn && clk_en && out_valid === 1'b1 && out_ready)
      outq.push_back(out_frame);
    if (resetn && clk_en && tdm_ov === 1'b1 && out_ready)
      tdm_q.push_back(tdm_of);
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fail_out();
    bad_count++;
    final_report();
  endtask

  // small distinct signed samples, well under any clip threshold
  function automatic pcf_frame_type mk(input int k);
    pcf_frame_type f;
    for (int a = 0; a < 4; a++) begin
      f[a].i = 16'(a * 256 + k + 1);
      f[a].q = -f[a].i;
    end
    return f;
  endfunction

  // expected interleaved frame: both live antennas see the same words
  function automatic pcf_frame_type mk_tdm(input int k);
    pcf_frame_type f;
    f = '0;
    for (int a = 0; a < 2; a++) begin
      f[a].i = 16'(k * 16 + 3);
      f[a].q = 16'(k * 16 + 2);
    end
    return f;
  endfunction

  // one interleaved word, held until the edge that takes it
  task automatic tdm_send(input logic [`PCF_DW-1:0] w, input bit ph);
    bit ok;
    ok = 1'b0;
    tdm_valid <= 1'b1;
    tdm_word  <= w;
    tdm_phase <= ph;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge clk_sys);
      ok = tdm_ready;
      @(posedge clk_sys);
    end
    if (!ok) fail_out();
  endtask

  task automatic push(input pcf_frame_type f);
    bit ok;
    src.send(f, 50, ok);
    if (!ok) fail_out();
  endtask

  task automatic wait_out(input int n);
    for (int c = 0; outq.size() < n; c++) begin
      if (c > 300) fail_out();
      @(posedge clk_sys);
    end
  endtask

  // sync reset: refuses input in its cycle, empties the pipeline
  task automatic clear();
    sync_reset_in <= 1'b1;
    @(negedge clk_sys);
    `CHK(in_ready, 1'b0)
    @(posedge clk_sys);
    sync_reset_in <= 1'b0;
    @(negedge clk_sys);
    `CHK(out_valid, 1'b0)
    outq.delete();
    @(posedge clk_sys);
  endtask

  // lone peak on antenna 0 followed by silence; two stages of four
  // advances each plus the hop between them put it at output nine
  task automatic peak_run();
    pcf_frame_type p;
    p = '0;
    p[0].i = 16'h1000;
    clear();
    push(p);
    for (int k = 0; k < 9; k++) push('0);
    src.idle();
    wait_out(10);
  endtask

  task automatic t_stream();
    clear();
    for (int k = 0; k < 12; k++) push(mk(k));
    src.idle();
    wait_out(12);
    for (int j = 0; j < 12; j++)
      `CHK(outq[j], (j < 9) ? pcf_frame_type'('0) : mk(j - 9))
  endtask

  // I word then Q word per frame; antennas two and three must read zero
  task automatic t_tdm();
    clear();
    tdm_q.delete();
    for (int k = 0; k < 12; k++) begin
      tdm_send(16'(k * 16 + 3), 1'b1);
      tdm_send(16'(k * 16 + 2), 1'b0);
    end
    tdm_valid <= 1'b0;
    tdm_word  <= 16'hffff;
    for (int c = 0; tdm_q.size() < 12; c++) begin
      if (c > 300) fail_out();
      @(posedge clk_sys);
    end
    for (int j = 0; j < 12; j++)
      `CHK(tdm_q[j], (j < 9) ? pcf_frame_type'('0) : mk_tdm(j - 9))
  endtask

  task automatic t_fill();
    int cnt;
    bit ok;
    pcf_frame_type f0;
    cnt = 0;
    ok = 1'b1;
    clear();
    out_ready <= 1'b0;
    while (ok && cnt < 20) begin
      src.send(mk(cnt), 3, ok);
      if (ok) cnt++;
    end
    src.idle();
    `CHK(cnt >= 16 && cnt <= 17, 1'b1)
    clk_en <= 1'b0;
    out_ready <= 1'b1;
    @(negedge clk_sys);
    f0 = out_frame;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(out_valid, 1'b1)
    `CHK(out_frame, f0)
    `CHK(outq.size(), 0)
    @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_out(cnt);
    repeat (20) @(posedge clk_sys);
    `CHK(outq.size(), cnt)
    @(negedge clk_sys);
    `CHK(in_ready, 1'b1)
    @(posedge clk_sys);
  endtask

  task automatic t_clip();
    thr[0] <= 16'h0800;
    thr[1] <= 16'h7fff;
    peak_run();
    `CHK(outq[9][0].i, 16'h0801)
    `CHK(outq[9][0].q, 16'h0000)
  endtask

  // centre tap of stage 0 rewritten live: no in-phase gain, and its
  // quadrature part must be dropped
  task automatic t_coef();
    coef_wr_en    <= 1'b1;
    coef_wr_stage <= 1'b0;
    coef_wr_tap   <= 2'h3; // centre only keeps the set symmetric
    coef_wr_data  <= '{i: 16'h0000, q: 16'h7fff};
    @(posedge clk_sys);
    coef_wr_en <= 1'b0;
    peak_run();
    `CHK(outq[9][0].i, 16'h1000)
    `CHK(outq[9][0].q, 16'h0000)
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(out_valid, 1'b0)
    `CHK(out_frame, pcf_frame_type'('0))
    `CHK(in_ready, 1'b1)
    @(posedge clk_sys);
    resetn <= 1'b1;
    t_stream();
    t_tdm();
    t_fill();
    t_clip();
    t_coef();
    final_report();
  end
endmodule
